// ===== rtl/gei_pkg.sv
// shared constants and types for the gpio edge interrupt unit
package gei_pkg;
    // register indices on the link
    localparam logic [6:0]  GEI_IDX_PIN_LEVEL  = 7'h5A;
    localparam logic [6:0]  GEI_IDX_PIN_DIR    = 7'h5C;
    localparam logic [6:0]  GEI_IDX_RISE_MASK  = 7'h5E;
    localparam logic [6:0]  GEI_IDX_FALL_MASK  = 7'h60;
    localparam logic [6:0]  GEI_IDX_PENDING    = 7'h62;
    localparam logic [6:0]  GEI_IDX_TOUCH_CTL  = 7'h64;

    // reset values
    localparam logic [15:0] GEI_RST_PIN_LEVEL  = 16'h0000;
    localparam logic [15:0] GEI_RST_PIN_DIR    = 16'h0000;
    localparam logic [15:0] GEI_RST_RISE_MASK  = 16'h0000;
    localparam logic [15:0] GEI_RST_FALL_MASK  = 16'h0000;
    localparam logic [15:0] GEI_RST_PENDING    = 16'h0000;
    localparam logic [15:0] GEI_RST_TOUCH_CTL  = 16'h0000;

    // field positions shared by the masks and the pending flags
    localparam int          GEI_GPIO_W         = 10;
    localparam int          GEI_SRC_W          = 15;
    localparam int          GEI_BIT_OVERFLOW   = 15;
    localparam int          GEI_BIT_SATURATION = 14;
    localparam int          GEI_BIT_XMINUS     = 13;
    localparam int          GEI_BIT_XPLUS      = 12;
    localparam int          GEI_BIT_CONV_DONE  = 11;
    localparam int          GEI_BIT_RESERVED   = 10;
    localparam logic [15:0] GEI_IRQ_BITS       = 16'hFBFF;

    // touch panel control fields
    localparam int          GEI_TCH_XMINUS_LVL = 13;
    localparam int          GEI_TCH_XPLUS_LVL  = 12;
    localparam int          GEI_TCH_BIAS       = 11;
    localparam int          GEI_TCH_OP_HI      = 9;
    localparam int          GEI_TCH_OP_LO      = 8;
    localparam logic [15:0] GEI_TCH_RW_BITS    = 16'h0FFF;

    // link frame bit counts
    localparam logic [7:0]  GEI_SLOT0_END      = 8'd15;
    localparam logic [7:0]  GEI_SLOT1_END      = 8'd35;
    localparam logic [7:0]  GEI_SLOT2_END      = 8'd55;
    localparam logic [7:0]  GEI_FRAME_LAST     = 8'd255;
    localparam logic [7:0]  GEI_OUT_BITS       = 8'd56;

    typedef enum logic [1:0] {
        GEI_LNK_IDLE = 2'b01,
        GEI_LNK_RUN  = 2'b10
    } gei_lnk_t;
endpackage

// ===== rtl/gei_aclink_engine.sv
// serial link slot engine: decodes register commands and returns read data
`timescale 1ns/1ps
module gei_aclink_engine import gei_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        bitClkPin,
    input  wire logic        syncPin,
    input  wire logic        sdataOutPin,
    input  wire logic [15:0] rdData,
    output logic             sdataInPin,
    output logic             regWrStb,
    output logic             regRdStb,
    output logic [6:0]       regIdx,
    output logic [15:0]      regWrData
);
    // index 0 bit clock, 1 frame sync, 2 serial data
    logic [2:0]  pinMetaFf;
    logic [2:0]  pinSyncFf;
    logic        clkPrevFf;
    gei_lnk_t    stateFf,     nxt_state;
    logic [7:0]  cntFf,       nxt_cnt;
    logic [19:0] shiftFf,     nxt_shift;
    logic [2:0]  tagFf,       nxt_tag;
    logic        cmdRdFf,     nxt_cmdRd;
    logic [6:0]  idxFf,       nxt_idx;
    logic        syncSeenFf,  nxt_syncSeen;
    logic        respPendFf,  nxt_respPend;
    logic [6:0]  respIdxFf,   nxt_respIdx;
    logic [15:0] respDataFf,  nxt_respData;
    logic [55:0] outFrameFf,  nxt_outFrame;
    logic        sdiFf,       nxt_sdi;
    logic        wrStbFf,     nxt_wrStb;
    logic        rdStbFf,     nxt_rdStb;
    logic [15:0] wrDataFf,    nxt_wrData;
    logic        bitRise;
    logic        bitFall;

    assign bitRise = pinSyncFf[0] & ~clkPrevFf;
    assign bitFall = ~pinSyncFf[0] & clkPrevFf;

    always_comb begin
        logic [19:0] shiftIn;
        logic [7:0]  outPos;
        shiftIn      = {shiftFf[18:0], pinSyncFf[2]};
        outPos       = 8'(GEI_OUT_BITS - 8'd1 - cntFf);
        nxt_state    = stateFf;
        nxt_cnt      = cntFf;
        nxt_shift    = shiftFf;
        nxt_tag      = tagFf;
        nxt_cmdRd    = cmdRdFf;
        nxt_idx      = idxFf;
        nxt_syncSeen = syncSeenFf;
        nxt_respPend = respPendFf;
        nxt_respIdx  = respIdxFf;
        nxt_respData = respDataFf;
        nxt_outFrame = outFrameFf;
        nxt_sdi      = sdiFf;
        nxt_wrStb    = 1'b0;
        nxt_rdStb    = 1'b0;
        nxt_wrData   = wrDataFf;
        if (bitFall) begin
            nxt_syncSeen = pinSyncFf[1];
            if (pinSyncFf[1] && !syncSeenFf) begin
                // sync is raised one bit ahead of the tag slot
                nxt_state    = GEI_LNK_RUN;
                nxt_cnt      = 8'd0;
                nxt_outFrame = {1'b1, respPendFf, respPendFf, 13'h0000,
                                1'b0, respIdxFf, 12'h000, respDataFf, 4'h0};
                nxt_respPend = 1'b0;
            end else if (stateFf == GEI_LNK_RUN) begin
                nxt_shift = shiftIn;
                nxt_cnt   = 8'(cntFf + 8'd1);
                if (cntFf == GEI_SLOT0_END) begin
                    nxt_tag = shiftIn[15:13];
                end
                if (cntFf == GEI_SLOT1_END) begin
                    nxt_cmdRd = shiftIn[19];
                    nxt_idx   = shiftIn[18:12];
                end
                if (cntFf == GEI_SLOT2_END && tagFf[2] && tagFf[1]) begin
                    if (cmdRdFf) begin
                        nxt_rdStb = 1'b1;
                    end else if (tagFf[0]) begin
                        nxt_wrStb  = 1'b1;
                        nxt_wrData = shiftIn[19:4];
                    end
                end
                if (cntFf == GEI_FRAME_LAST) begin
                    nxt_state = GEI_LNK_IDLE;
                end
            end
        end
        // read answer rides in the next frame
        if (rdStbFf) begin
            nxt_respPend = 1'b1;
            nxt_respIdx  = idxFf;
            nxt_respData = rdData;
        end
        if (bitRise) begin
            nxt_sdi = (stateFf == GEI_LNK_RUN && cntFf < GEI_OUT_BITS) ? outFrameFf[outPos[5:0]] : 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinMetaFf  <= 3'h0;
            pinSyncFf  <= 3'h0;
            clkPrevFf  <= 1'b0;
            stateFf    <= GEI_LNK_IDLE;
            cntFf      <= 8'h00;
            shiftFf    <= 20'h00000;
            tagFf      <= 3'h0;
            cmdRdFf    <= 1'b0;
            idxFf      <= 7'h00;
            syncSeenFf <= 1'b0;
            respPendFf <= 1'b0;
            respIdxFf  <= 7'h00;
            respDataFf <= 16'h0000;
            outFrameFf <= 56'h00000000000000;
            sdiFf      <= 1'b0;
            wrStbFf    <= 1'b0;
            rdStbFf    <= 1'b0;
            wrDataFf   <= 16'h0000;
        end else begin
            pinMetaFf  <= {sdataOutPin, syncPin, bitClkPin};
            pinSyncFf  <= pinMetaFf;
            clkPrevFf  <= pinSyncFf[0];
            stateFf    <= nxt_state;
            cntFf      <= nxt_cnt;
            shiftFf    <= nxt_shift;
            tagFf      <= nxt_tag;
            cmdRdFf    <= nxt_cmdRd;
            idxFf      <= nxt_idx;
            syncSeenFf <= nxt_syncSeen;
            respPendFf <= nxt_respPend;
            respIdxFf  <= nxt_respIdx;
            respDataFf <= nxt_respData;
            outFrameFf <= nxt_outFrame;
            sdiFf      <= nxt_sdi;
            wrStbFf    <= nxt_wrStb;
            rdStbFf    <= nxt_rdStb;
            wrDataFf   <= nxt_wrData;
        end
    end

    assign sdataInPin = sdiFf;
    assign regWrStb   = wrStbFf;
    assign regRdStb   = rdStbFf;
    assign regIdx     = idxFf;
    assign regWrData  = wrDataFf;
endmodule

// ===== rtl/gei_gpio_edge_irq.sv
// gpio port with edge interrupt unit and touch panel control, reached over the serial link
//
// Notes on behaviour
// - pin-level read returns sensed pin levels
// - written level drives only output pins
// - direction bit one makes pin output
// - direction and level registers reset to zero
// - rising enables for five non-pin sources
// - falling enables for five non-pin sources
// - rising enables for the ten pins
// - falling enables for the ten pins
// - conversion done is source bit eleven
// - bit ten reserved, reads zero
// - pending read shows latched status flags
// - write one clears a non-pin flag
// - write one clears each pin flag
// - masks, flags, touch control reset zero
// - touch bit thirteen shows x-minus level
// - touch bit twelve shows x-plus level
// - touch bit eleven enables panel bias
// - touch bits nine-eight select operation
`timescale 1ns/1ps
module gei_gpio_edge_irq import gei_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        bitClkPin,
    input  wire logic        syncPin,
    input  wire logic        sdataOutPin,
    output logic             sdataInPin,
    input  wire logic [9:0]  gpioPinIn,
    output logic [9:0]       gpioPinOut,
    output logic [9:0]       gpioPinOeN,
    input  wire logic        rangeExceedFlag,
    input  wire logic        audioSaturationFlag,
    input  wire logic        touchXMinusPin,
    input  wire logic        touchXPlusPin,
    input  wire logic        convDone,
    output logic             irqOut,
    output logic             touchBiasEn,
    output logic [1:0]       touchOpSelect
);
    logic                 regWrStb;
    logic                 regRdStb;
    logic [6:0]           regIdx;
    logic [15:0]          regWrData;
    logic [15:0]          rdData;

    logic [GEI_SRC_W-1:0] srcMetaFf;
    logic [GEI_SRC_W-1:0] srcSyncFf;
    logic [GEI_SRC_W-1:0] srcPrevFf;
    logic [15:0]          srcLvl;
    logic [15:0]          srcPrev;
    logic [15:0]          riseHit;
    logic [15:0]          fallHit;

    logic [9:0]           levelFf,     nxt_level;
    logic [9:0]           dirFf,       nxt_dir;
    logic [15:0]          riseMaskFf,  nxt_riseMask;
    logic [15:0]          fallMaskFf,  nxt_fallMask;
    logic [15:0]          pendFf,      nxt_pend;
    logic [15:0]          touchCtlFf,  nxt_touchCtl;
    logic                 irqFf,       nxt_irq;

    gei_aclink_engine u_link (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .bitClkPin   (bitClkPin),
        .syncPin     (syncPin),
        .sdataOutPin (sdataOutPin),
        .rdData      (rdData),
        .sdataInPin  (sdataInPin),
        .regWrStb    (regWrStb),
        .regRdStb    (regRdStb),
        .regIdx      (regIdx),
        .regWrData   (regWrData)
    );

    // all event sources are asynchronous to ref_clk; edges are taken from the second stage
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            srcMetaFf <= '0;
            srcSyncFf <= '0;
            srcPrevFf <= '0;
        end else begin
            srcMetaFf <= {rangeExceedFlag, audioSaturationFlag, touchXMinusPin, touchXPlusPin,
                          convDone, gpioPinIn};
            srcSyncFf <= srcMetaFf;
            srcPrevFf <= srcSyncFf;
        end
    end

    // bit ten holds no source
    assign srcLvl  = {srcSyncFf[14:10], 1'b0, srcSyncFf[9:0]};
    assign srcPrev = {srcPrevFf[14:10], 1'b0, srcPrevFf[9:0]};

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_edge
            assign riseHit[gi] = srcLvl[gi] & ~srcPrev[gi] & riseMaskFf[gi];
            assign fallHit[gi] = ~srcLvl[gi] & srcPrev[gi] & fallMaskFf[gi];
        end
    endgenerate

    always_comb begin
        logic [15:0] clrBits;
        logic        wrHit;
        clrBits      = 16'h0000;
        wrHit        = regWrStb;
        nxt_level    = levelFf;
        nxt_dir      = dirFf;
        nxt_riseMask = riseMaskFf;
        nxt_fallMask = fallMaskFf;
        nxt_touchCtl = touchCtlFf;
        if (wrHit) begin
            case (regIdx)
                GEI_IDX_PIN_LEVEL: nxt_level    = regWrData[GEI_GPIO_W-1:0];
                GEI_IDX_PIN_DIR:   nxt_dir      = regWrData[GEI_GPIO_W-1:0];
                GEI_IDX_RISE_MASK: nxt_riseMask = regWrData & GEI_IRQ_BITS;
                GEI_IDX_FALL_MASK: nxt_fallMask = regWrData & GEI_IRQ_BITS;
                GEI_IDX_PENDING:   clrBits      = regWrData & GEI_IRQ_BITS;
                GEI_IDX_TOUCH_CTL: nxt_touchCtl = regWrData & GEI_TCH_RW_BITS;
                default: ;
            endcase
        end
        // a new edge in the clearing cycle wins over the clear
        nxt_pend = ((pendFf & ~clrBits) | riseHit | fallHit) & GEI_IRQ_BITS;
        nxt_irq  = |nxt_pend;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            levelFf    <= GEI_RST_PIN_LEVEL[GEI_GPIO_W-1:0];
            dirFf      <= GEI_RST_PIN_DIR[GEI_GPIO_W-1:0];
            riseMaskFf <= GEI_RST_RISE_MASK;
            fallMaskFf <= GEI_RST_FALL_MASK;
            pendFf     <= GEI_RST_PENDING;
            touchCtlFf <= GEI_RST_TOUCH_CTL;
            irqFf      <= 1'b0;
            gpioPinOut <= 10'h000;
            gpioPinOeN <= 10'h3FF;
            touchBiasEn   <= 1'b0;
            touchOpSelect <= 2'h0;
        end else begin
            levelFf    <= nxt_level;
            dirFf      <= nxt_dir;
            riseMaskFf <= nxt_riseMask;
            fallMaskFf <= nxt_fallMask;
            pendFf     <= nxt_pend;
            touchCtlFf <= nxt_touchCtl;
            irqFf      <= nxt_irq;
            gpioPinOut <= nxt_level;
            gpioPinOeN <= ~nxt_dir;
            touchBiasEn   <= nxt_touchCtl[GEI_TCH_BIAS];
            touchOpSelect <= nxt_touchCtl[GEI_TCH_OP_HI:GEI_TCH_OP_LO];
        end
    end

    assign irqOut = irqFf;

    // read data is sampled by the link engine in the strobe cycle
    always_comb begin
        rdData = 16'h0000;
        case (regIdx)
            GEI_IDX_PIN_LEVEL: rdData = {6'h00, srcSyncFf[GEI_GPIO_W-1:0]};
            GEI_IDX_PIN_DIR:   rdData = {6'h00, dirFf};
            GEI_IDX_RISE_MASK: rdData = riseMaskFf;
            GEI_IDX_FALL_MASK: rdData = fallMaskFf;
            GEI_IDX_PENDING:   rdData = pendFf;
            GEI_IDX_TOUCH_CTL: begin
                rdData = touchCtlFf;
                rdData[GEI_TCH_XMINUS_LVL] = srcSyncFf[GEI_BIT_XMINUS - 1];
                rdData[GEI_TCH_XPLUS_LVL]  = srcSyncFf[GEI_BIT_XPLUS - 1];
            end
            default: rdData = 16'h0000;
        endcase
    end

    chk_level_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regRdStb && regIdx == GEI_IDX_PIN_LEVEL) |-> rdData == {6'h00, srcSyncFf[9:0]})
        else $error("pin level read does not show sensed pins");

    chk_level_drive: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regWrStb && regIdx == GEI_IDX_PIN_LEVEL) |=> gpioPinOut == $past(regWrData[9:0]))
        else $error("written level not driven on pins");

    chk_dir_enable: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regWrStb && regIdx == GEI_IDX_PIN_DIR) |=> gpioPinOeN == ~$past(regWrData[9:0]))
        else $error("direction write did not steer output enables");

    chk_rise_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (|riseHit) |=> ((pendFf & $past(riseHit)) == $past(riseHit)) && irqOut)
        else $error("enabled rising edge did not set its flag");

    chk_fall_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (|fallHit) |=> ((pendFf & $past(fallHit)) == $past(fallHit)) && irqOut)
        else $error("enabled falling edge did not set its flag");

    chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !pendFf[GEI_BIT_RESERVED] && !riseMaskFf[GEI_BIT_RESERVED] && !fallMaskFf[GEI_BIT_RESERVED])
        else $error("reserved bit ten became set");

    chk_pend_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regWrStb && regIdx == GEI_IDX_PENDING && !(|riseHit) && !(|fallHit))
        |=> pendFf == ($past(pendFf) & ~$past(regWrData)))
        else $error("write one did not clear exactly the written flags");

    chk_pend_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(regWrStb && regIdx == GEI_IDX_PENDING) |=> (pendFf & $past(pendFf)) == $past(pendFf))
        else $error("pending flag dropped without a clear");

    chk_irq_level: assert property (@(posedge ref_clk) disable iff (!arst_n)
        irqOut == (|pendFf))
        else $error("interrupt output disagrees with pending flags");

    chk_bias_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regWrStb && regIdx == GEI_IDX_TOUCH_CTL)
        |=> touchBiasEn == $past(regWrData[11]) && touchOpSelect == $past(regWrData[9:8]))
        else $error("touch control write not applied");

    // pin flags clear one by one, each by its own bit
    chk_pin_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regWrStb && regIdx == GEI_IDX_PENDING && riseHit[9:0] == 10'h000 && fallHit[9:0] == 10'h000)
        |=> pendFf[9:0] == ($past(pendFf[9:0]) & ~$past(regWrData[9:0])))
        else $error("pin flag clear did not follow the written ones");

    chk_pend_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regRdStb && regIdx == GEI_IDX_PENDING) |-> rdData == pendFf)
        else $error("pending read does not show latched flags");

    chk_xminus_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regRdStb && regIdx == GEI_IDX_TOUCH_CTL) |-> rdData[13] == srcLvl[GEI_BIT_XMINUS])
        else $error("touch read does not show x-minus level");

    chk_xplus_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regRdStb && regIdx == GEI_IDX_TOUCH_CTL) |-> rdData[12] == srcLvl[GEI_BIT_XPLUS])
        else $error("touch read does not show x-plus level");

    chk_op_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
        touchOpSelect == touchCtlFf[9:8])
        else $error("operation select differs from stored field");

    chk_conv_rise: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (srcLvl[GEI_BIT_CONV_DONE] && !srcPrev[GEI_BIT_CONV_DONE] && riseMaskFf[11]) |=> pendFf[11])
        else $error("conversion done edge did not set its flag");

    chk_gpio_rise: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (riseHit[9:0] != 10'h000) |=> (pendFf[9:0] & $past(riseHit[9:0])) == $past(riseHit[9:0]))
        else $error("pin rising edge did not set its flag");

    chk_gpio_fall: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (fallHit[9:0] != 10'h000) |=> (pendFf[9:0] & $past(fallHit[9:0])) == $past(fallHit[9:0]))
        else $error("pin falling edge did not set its flag");

    chk_rise_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regWrStb && regIdx == GEI_IDX_RISE_MASK) |=> riseMaskFf == ($past(regWrData) & GEI_IRQ_BITS))
        else $error("rising mask write not stored");

    chk_fall_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (regWrStb && regIdx == GEI_IDX_FALL_MASK) |=> fallMaskFf == ($past(regWrData) & GEI_IRQ_BITS))
        else $error("falling mask write not stored");

    chk_level_store: assert property (@(posedge ref_clk) disable iff (!arst_n)
        gpioPinOut == levelFf)
        else $error("pin drive differs from stored level");

    chk_oe_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
        gpioPinOeN == ~dirFf)
        else $error("output enables differ from direction bits");
endmodule

// ===== dv/gei_link_host.sv
// behavioural serial-link host: one register command per frame, captures the reply slots
`timescale 1ns/1ps
module gei_link_host #(
    parameter int HALF = 80
) (
    output logic      bitClkPin,
    output logic      syncPin,
    output logic      sdataOutPin,
    input  wire logic sdataInPin
);
    initial begin
        bitClkPin   = 1'b0;
        syncPin     = 1'b0;
        sdataOutPin = 1'b0;
    end

    // the bit clock stands low between frames, so each frame pays one full bit clock period (two half periods) of lead-in
    task automatic frame(
        input  logic        rdCmd,
        input  logic [6:0]  idx,
        input  logic [15:0] wrData,
        output logic [2:0]  tag,
        output logic [6:0]  echo,
        output logic [15:0] rdData
    );
        logic [255:0] tx;
        logic [255:0] rx;
        tx = '0;
        rx = '0;
        tx[0]  = 1'b1;
        tx[1]  = 1'b1;
        tx[2]  = ~rdCmd;
        tx[16] = rdCmd;
        for (int i = 0; i < 7; i++) tx[17+i] = idx[6-i];
        for (int i = 0; i < 16; i++) tx[36+i] = wrData[15-i];
        // odd offset keeps link edges away from the system clock edges
        #3;
        syncPin = 1'b1;
        #(HALF) bitClkPin = 1'b1;
        #(HALF) bitClkPin = 1'b0;
        for (int k = 0; k < 256; k++) begin
            #(HALF) bitClkPin = 1'b1;
            #1 sdataOutPin = tx[k];
            if (k == 15) syncPin = 1'b0;
            #(HALF - 1) bitClkPin = 1'b0;
            rx[k] = sdataInPin;
        end
        // idle line shows the inverse so a stale bit cannot pass for fresh data
        sdataOutPin = ~sdataOutPin;
        for (int i = 0; i < 3; i++) tag[i] = rx[i];
        for (int i = 0; i < 7; i++) echo[6-i] = rx[17+i];
        for (int i = 0; i < 16; i++) rdData[15-i] = rx[36+i];
    endtask
endmodule

// ===== dv/tb_gei_gpio_edge_irq.sv
// self-checking bench for the gpio edge interrupt unit, driven through the link host model
`timescale 1ns/1ps
module tb_gei_gpio_edge_irq import gei_pkg::*;;
    localparam logic RD = 1'b1;
    localparam logic WR = 1'b0;

    logic        ref_clk, arst_n, bitClkPin, syncPin, sdataOutPin, sdataInPin;
    logic [9:0]  gpioPinIn, gpioPinOut, gpioPinOeN, extLevel;
    logic        rangeExceedFlag, audioSaturationFlag, touchXMinusPin, touchXPlusPin, convDone;
    logic        irqOut, touchBiasEn, pendRd;
    logic [1:0]  touchOpSelect;
    logic [6:0]  pendIdx;
    logic [15:0] pendExp;
    int          errTotal, checkCount, cycles;

    // pins set as outputs carry the design's drive, the rest the outside level
    assign gpioPinIn = (~gpioPinOeN & gpioPinOut) | (gpioPinOeN & extLevel);

    gei_link_host host (
        .bitClkPin   (bitClkPin),
        .syncPin     (syncPin),
        .sdataOutPin (sdataOutPin),
        .sdataInPin  (sdataInPin)
    );

    gei_gpio_edge_irq dut (
        .ref_clk             (ref_clk),
        .arst_n              (arst_n),
        .bitClkPin           (bitClkPin),
        .syncPin             (syncPin),
        .sdataOutPin         (sdataOutPin),
        .sdataInPin          (sdataInPin),
        .gpioPinIn           (gpioPinIn),
        .gpioPinOut          (gpioPinOut),
        .gpioPinOeN          (gpioPinOeN),
        .rangeExceedFlag     (rangeExceedFlag),
        .audioSaturationFlag (audioSaturationFlag),
        .touchXMinusPin      (touchXMinusPin),
        .touchXPlusPin       (touchXPlusPin),
        .convDone            (convDone),
        .irqOut              (irqOut),
        .touchBiasEn         (touchBiasEn),
        .touchOpSelect       (touchOpSelect)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stopTest();
        if (errTotal == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a read answer arrives one frame late, so each frame checks the previous command's reply
    task automatic op(input logic isRd, input logic [6:0] idx, input logic [15:0] val);
        logic [2:0]  tag;
        logic [6:0]  echo;
        logic [15:0] data;
        host.frame(isRd, idx, val, tag, echo, data);
        check("reply tag", 16'(tag), pendRd ? 16'h0007 : 16'h0001);
        if (pendRd) begin
            check("reply index", 16'(echo), 16'(pendIdx));
            check("reply data", data, pendExp);
        end
        pendRd  = isRd;
        pendIdx = idx;
        pendExp = val;
        @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 95000) begin
            errTotal++;
            stopTest();
        end
    end

    initial begin
        ref_clk             = 1'b0;
        arst_n              = 1'b0;
        extLevel            = 10'h2AA;
        rangeExceedFlag     = 1'b0;
        audioSaturationFlag = 1'b0;
        touchXMinusPin      = 1'b0;
        touchXPlusPin       = 1'b1;
        convDone            = 1'b0;
        pendRd              = 1'b0;
        pendIdx             = 7'h00;
        pendExp             = 16'h0000;
        errTotal            = 0;
        checkCount          = 0;
        cycles              = 0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("oe after reset", 16'(gpioPinOeN), 16'h03FF);
        check("drive after reset", 16'(gpioPinOut), 16'h0000);
        check("irq after reset", 16'(irqOut), 16'h0000);
        check("bias after reset", 16'({touchBiasEn, touchOpSelect}), 16'h0000);
        op(RD, GEI_IDX_RISE_MASK, 16'h0000);
        op(RD, GEI_IDX_PENDING, 16'h0000);
        op(RD, GEI_IDX_TOUCH_CTL, 16'h1000);
        op(WR, GEI_IDX_PIN_DIR, 16'h000F);
        op(WR, GEI_IDX_PIN_LEVEL, 16'h03A5);
        check("oe after dir", 16'(gpioPinOeN), 16'h03F0);
        check("driven pins", 16'(gpioPinOut & ~gpioPinOeN), 16'h0005);
        op(RD, GEI_IDX_PIN_LEVEL, 16'h02A5);
        op(RD, 7'h20, 16'h0000);
        op(WR, GEI_IDX_RISE_MASK, 16'hFFFF);
        op(WR, GEI_IDX_FALL_MASK, 16'h0820);
        op(RD, GEI_IDX_RISE_MASK, 16'hFBFF);
        check("irq idle", 16'(irqOut), 16'h0000);
        @(posedge ref_clk);
        rangeExceedFlag     <= 1'b1;
        audioSaturationFlag <= 1'b1;
        convDone            <= 1'b1;
        touchXMinusPin      <= 1'b1;
        touchXPlusPin       <= 1'b0;
        extLevel            <= 10'h29A;
        repeat (10) @(posedge ref_clk);
        check("irq on edges", 16'(irqOut), 16'h0001);
        op(RD, GEI_IDX_PENDING, 16'hE830);
        op(WR, GEI_IDX_PENDING, 16'h4410);
        op(RD, GEI_IDX_PENDING, 16'hA820);
        op(WR, GEI_IDX_PENDING, 16'hFFFF);
        check("irq cleared", 16'(irqOut), 16'h0000);
        convDone <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check("irq on fall", 16'(irqOut), 16'h0001);
        op(WR, GEI_IDX_TOUCH_CTL, 16'hFB01);
        check("bias on", 16'(touchBiasEn), 16'h0001);
        check("touch op", 16'(touchOpSelect), 16'h0003);
        op(RD, GEI_IDX_TOUCH_CTL, 16'h2B01);
        op(RD, GEI_IDX_PENDING, 16'h0800);
        op(WR, 7'h20, 16'h1234);
        stopTest();
    end
endmodule
